// *** eirq_map.svh ***
// Register offsets, bit positions and reset values of the interrupt block
`ifndef EIRQ_MAP_SVH
`define EIRQ_MAP_SVH
`define EIRQ_ADDR_EXT_EN_TWO 8'hA5
`define EIRQ_ADDR_EXT_EN_ONE 8'hAD
`define EIRQ_ADDR_EXT_PRI_LOW 8'hAE
`define EIRQ_ADDR_EXT_PRI_HIGH 8'hAF
`define EIRQ_ADDR_BASE_PRI_LOW 8'hB6
`define EIRQ_ADDR_BASE_PRI_HIGH 8'hB7
`define EIRQ_ADDR_XREQ_CTRL 8'hC0
`define EIRQ_ADDR_GLOBAL 8'hC8
`define EIRQ_ADDR_SYS_FLAG_EN 8'hC9
`define EIRQ_RESET_BYTE 8'h00
`define EIRQ_BIT_POL3 7
`define EIRQ_BIT_EN3 6
`define EIRQ_BIT_PEND3 5
`define EIRQ_BIT_EDGE3 4
`define EIRQ_BIT_POL2 3
`define EIRQ_BIT_EN2 2
`define EIRQ_BIT_PEND2 1
`define EIRQ_BIT_EDGE2 0
`define EIRQ_BIT_RSVD5 5
`define EIRQ_BIT_GLOBAL 0
`define EIRQ_BIT_KEYPAD 5
`define EIRQ_BIT_SYSFLAG 3
`define EIRQ_BIT_CONV 1
`define EIRQ_BIT_SPI 0
`define EIRQ_SRC_REQ2 6
`define EIRQ_SRC_REQ3 7
`define EIRQ_WR_HOLD 2'h2
`endif

// *** eirq_pkg.sv ***
// Types shared by the interrupt enable and priority block
package eirq_pkg;
	typedef enum logic [1:0] {
		EIRQ_LVL4,
		EIRQ_LVL3,
		EIRQ_LVL2,
		EIRQ_LVL1
	} eirq_level_e;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} eirq_bus_s;

	typedef struct packed {
		logic [9:0] sys_flags;
		logic [7:0] ext1_raw;
		logic [6:0] ext2_raw;
		logic [7:0] base_raw;
	} eirq_src_s;
endpackage

// *** eirq_edge.sv ***
// Sync, polarity and edge/level detection for one external request pin
`timescale 1ns/1ps
module eirq_edge
	import eirq_pkg::*;
(
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// Pin and mode
	input wire logic pin,
	input wire logic pol_high,
	input wire logic edge_mode,
	// Results
	output logic active_level,
	output logic edge_hit
);
	typedef struct packed {
		logic s1;
		logic s2;
		logic prev;
	} eirq_edge_s;

	eirq_edge_s st_r;
	eirq_edge_s st_nxt;
	logic sense;

	// Two-stage sync, then sense per polarity
	always_comb begin
		st_nxt = st_r;
		st_nxt.s1 = pin;
		st_nxt.s2 = st_r.s1;
		st_nxt.prev = st_r.s2;
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			// Start at the pin's idle high level: no false edge
			st_r <= '1;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign sense = pol_high ? st_r.s2 : ~st_r.s2;
	assign active_level = sense;
	assign edge_hit = edge_mode &
		(pol_high ? (st_r.s2 & ~st_r.prev) : (~st_r.s2 & st_r.prev));

	edge_polarity_a: assert property (
		@(posedge clock) disable iff (!rst_n)
		edge_hit |-> (pol_high ? st_r.s2 : !st_r.s2))
		else $error("edge reported against the selected polarity");
	edge_mode_a: assert property (
		@(posedge clock) disable iff (!rst_n)
		!edge_mode |-> !edge_hit)
		else $error("edge reported in level mode");
endmodule

// *** eirq_level.sv ***
// Combines high and low priority bits into a four-level code per source
`timescale 1ns/1ps
module eirq_level
	import eirq_pkg::*;
(
	// Priority bytes
	input wire logic [7:0] pri_high,
	input wire logic [7:0] pri_low,
	// Levels
	output eirq_level_e levels [8]
);
	genvar i;
	generate
		for (i = 0; i < 8; i++) begin : g_lvl
			assign levels[i] = eirq_level_e'({pri_high[i], pri_low[i]});
		end
	endgenerate
endmodule

// *** eirq_ctrl.sv ***
// External request 2/3 control plus enable and priority registers
`timescale 1ns/1ps
`include "eirq_map.svh"
module eirq_ctrl
	import eirq_pkg::*;
(
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// CPU register access
	input wire eirq_bus_s bus,
	output logic [7:0] rdata,
	// CPU state and service
	input wire logic idle_state,
	input wire logic power_down_state,
	input wire logic instr_end,
	input wire logic service_req2,
	input wire logic service_req3,
	// Peripheral flags and pins
	input wire eirq_src_s src,
	input wire logic external_request_2_pin,
	input wire logic external_request_3_pin,
	// Requests to the core
	output logic [7:0] base_req,
	output logic [7:0] ext1_req,
	output logic [7:0] ext2_req,
	output logic [15:0] base_level,
	output logic [15:0] ext1_level,
	output logic vector_block,
	output logic wake_up
);
	typedef struct packed {
		logic [7:0] xreq_ctrl;
		logic [7:0] ext_en_one;
		logic [7:0] ext_en_two;
		logic [7:0] ext_pri_low;
		logic [7:0] ext_pri_high;
		logic [7:0] base_pri_low;
		logic [7:0] base_pri_high;
		logic [7:0] global_ctrl;
		logic [7:0] system_flag_enable_reg;
		logic [7:0] rdata;
		logic [7:0] base_req;
		logic [7:0] ext1_req;
		logic [7:0] ext2_req;
		logic [15:0] base_level;
		logic [15:0] ext1_level;
		logic [1:0] hold;
		logic block;
		logic wake;
	} eirq_state_s;

	eirq_state_s st_r;
	eirq_state_s st_nxt;
	logic lvl2;
	logic lvl3;
	logic edge2;
	logic edge3;
	logic sys_any;
	logic gate;
	logic reg_wr;
	logic en2;
	logic en3;
	logic pend2;
	logic pend3;
	eirq_level_e base_lv [8];
	eirq_level_e ext_lv [8];

	// Decode of a register address, used only for the write hold-off
	function automatic logic is_mapped(input logic [7:0] a);
		is_mapped = (a == `EIRQ_ADDR_EXT_EN_TWO) ||
			(a == `EIRQ_ADDR_EXT_EN_ONE) ||
			(a == `EIRQ_ADDR_EXT_PRI_LOW) ||
			(a == `EIRQ_ADDR_EXT_PRI_HIGH) ||
			(a == `EIRQ_ADDR_BASE_PRI_LOW) ||
			(a == `EIRQ_ADDR_BASE_PRI_HIGH) ||
			(a == `EIRQ_ADDR_XREQ_CTRL) ||
			(a == `EIRQ_ADDR_GLOBAL) ||
			(a == `EIRQ_ADDR_SYS_FLAG_EN);
	endfunction

	// Pin detectors for the two external requests
	eirq_edge u_req2 (
		.clock(clock),
		.rst_n(rst_n),
		.pin(external_request_2_pin),
		.pol_high(st_r.xreq_ctrl[`EIRQ_BIT_POL2]),
		.edge_mode(st_r.xreq_ctrl[`EIRQ_BIT_EDGE2]),
		.active_level(lvl2),
		.edge_hit(edge2)
	);

	eirq_edge u_req3 (
		.clock(clock),
		.rst_n(rst_n),
		.pin(external_request_3_pin),
		.pol_high(st_r.xreq_ctrl[`EIRQ_BIT_POL3]),
		.edge_mode(st_r.xreq_ctrl[`EIRQ_BIT_EDGE3]),
		.active_level(lvl3),
		.edge_hit(edge3)
	);

	// Priority level decode for both groups
	eirq_level u_base_lv (
		.pri_high(st_r.base_pri_high),
		.pri_low(st_r.base_pri_low),
		.levels(base_lv)
	);

	eirq_level u_ext_lv (
		.pri_high(st_r.ext_pri_high),
		.pri_low(st_r.ext_pri_low),
		.levels(ext_lv)
	);

	// System flag group and global gate
	// per-flag enable (flags 1:0 share global_ctrl bit 1) then group enable
	assign sys_any = |(src.sys_flags &
		{st_r.system_flag_enable_reg, {2{st_r.global_ctrl[1]}}});
	assign gate = st_r.global_ctrl[`EIRQ_BIT_GLOBAL];
	assign reg_wr = bus.wr && is_mapped(bus.addr) &&
		(bus.addr != `EIRQ_ADDR_SYS_FLAG_EN);
	// Enable and pending bits of the current control byte
	assign en2 = st_r.xreq_ctrl[`EIRQ_BIT_EN2];
	assign en3 = st_r.xreq_ctrl[`EIRQ_BIT_EN3];
	assign pend2 = st_r.xreq_ctrl[`EIRQ_BIT_PEND2];
	assign pend3 = st_r.xreq_ctrl[`EIRQ_BIT_PEND3];

	// Next-state logic
	always_comb begin
		logic [7:0] x;
		logic [7:0] e1;
		x = st_r.xreq_ctrl;
		e1 = '0;
		st_nxt = st_r;
		// Register writes
		if (bus.wr) begin
			case (bus.addr)
				`EIRQ_ADDR_XREQ_CTRL: x = bus.wdata;
				`EIRQ_ADDR_EXT_EN_ONE: st_nxt.ext_en_one = bus.wdata;
				`EIRQ_ADDR_EXT_EN_TWO: begin
					st_nxt.ext_en_two = bus.wdata;
					st_nxt.ext_en_two[`EIRQ_BIT_RSVD5] = 1'b0;
				end
				`EIRQ_ADDR_EXT_PRI_LOW: st_nxt.ext_pri_low = bus.wdata;
				`EIRQ_ADDR_EXT_PRI_HIGH: st_nxt.ext_pri_high = bus.wdata;
				`EIRQ_ADDR_BASE_PRI_LOW: st_nxt.base_pri_low = bus.wdata;
				`EIRQ_ADDR_BASE_PRI_HIGH: st_nxt.base_pri_high = bus.wdata;
				`EIRQ_ADDR_GLOBAL: st_nxt.global_ctrl = bus.wdata;
				`EIRQ_ADDR_SYS_FLAG_EN:
					st_nxt.system_flag_enable_reg = bus.wdata;
				default: ;
			endcase
		end
		if (service_req2) begin
			x[`EIRQ_BIT_PEND2] = 1'b0;
		end
		if (service_req3) begin
			x[`EIRQ_BIT_PEND3] = 1'b0;
		end
		if (st_r.xreq_ctrl[`EIRQ_BIT_EDGE2]) begin
			if (edge2) begin
				x[`EIRQ_BIT_PEND2] = 1'b1;
			end
		end else if (!(bus.wr && bus.addr == `EIRQ_ADDR_XREQ_CTRL)) begin
			x[`EIRQ_BIT_PEND2] = lvl2;
		end
		if (st_r.xreq_ctrl[`EIRQ_BIT_EDGE3]) begin
			if (edge3) begin
				x[`EIRQ_BIT_PEND3] = 1'b1;
			end
		end else if (!(bus.wr && bus.addr == `EIRQ_ADDR_XREQ_CTRL)) begin
			x[`EIRQ_BIT_PEND3] = lvl3;
		end
		st_nxt.xreq_ctrl = x;
		// Register read data
		case (bus.addr)
			`EIRQ_ADDR_XREQ_CTRL: st_nxt.rdata = st_r.xreq_ctrl;
			`EIRQ_ADDR_EXT_EN_ONE: st_nxt.rdata = st_r.ext_en_one;
			`EIRQ_ADDR_EXT_EN_TWO: st_nxt.rdata = st_r.ext_en_two;
			`EIRQ_ADDR_EXT_PRI_LOW: st_nxt.rdata = st_r.ext_pri_low;
			`EIRQ_ADDR_EXT_PRI_HIGH: st_nxt.rdata = st_r.ext_pri_high;
			`EIRQ_ADDR_BASE_PRI_LOW: st_nxt.rdata = st_r.base_pri_low;
			`EIRQ_ADDR_BASE_PRI_HIGH: st_nxt.rdata = st_r.base_pri_high;
			`EIRQ_ADDR_GLOBAL: st_nxt.rdata = st_r.global_ctrl;
			`EIRQ_ADDR_SYS_FLAG_EN:
				st_nxt.rdata = st_r.system_flag_enable_reg;
			default: st_nxt.rdata = `EIRQ_RESET_BYTE;
		endcase
		if (!bus.rd) begin
			st_nxt.rdata = st_r.rdata;
		end
		e1 = src.ext1_raw;
		e1[`EIRQ_BIT_SYSFLAG] = sys_any;
		st_nxt.ext1_req = gate ? (e1 & st_r.ext_en_one) : '0;
		st_nxt.ext2_req = gate ?
			({src.ext2_raw[6:5], 1'b0, src.ext2_raw[4:0]} &
			st_r.ext_en_two) : '0;
		st_nxt.base_req = src.base_raw;
		st_nxt.base_req[`EIRQ_SRC_REQ2] =
			st_r.xreq_ctrl[`EIRQ_BIT_PEND2] &
			st_r.xreq_ctrl[`EIRQ_BIT_EN2];
		st_nxt.base_req[`EIRQ_SRC_REQ3] =
			st_r.xreq_ctrl[`EIRQ_BIT_PEND3] &
			st_r.xreq_ctrl[`EIRQ_BIT_EN3];
		if (!gate) begin
			st_nxt.base_req = '0;
		end
		for (int i = 0; i < 8; i++) begin
			st_nxt.base_level[2*i +: 2] = base_lv[i];
			st_nxt.ext1_level[2*i +: 2] = ext_lv[i];
		end
		// wake when enabled pending in sleep
		st_nxt.wake = (idle_state | power_down_state) &
			((x[`EIRQ_BIT_PEND2] & x[`EIRQ_BIT_EN2]) |
			(x[`EIRQ_BIT_PEND3] & x[`EIRQ_BIT_EN3]));
		// hold off vectoring past next instruction
		if (reg_wr) begin
			st_nxt.hold = `EIRQ_WR_HOLD;
		end else if (instr_end && st_r.hold != 2'h0) begin
			st_nxt.hold = st_r.hold - 2'h1;
		end
		st_nxt.block = (st_nxt.hold != 2'h0);
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	// Outputs straight from flops
	assign rdata = st_r.rdata;
	assign base_req = st_r.base_req;
	assign ext1_req = st_r.ext1_req;
	assign ext2_req = st_r.ext2_req;
	assign base_level = st_r.base_level;
	assign ext1_level = st_r.ext1_level;
	assign vector_block = st_r.block;
	assign wake_up = st_r.wake;

	// Checks share the system clock and stay quiet in reset
	default clocking chk_cb @(posedge clock);
	endclocking
	default disable iff (!rst_n);

	// Gating of every request vector
	global_gate_a: assert property (
		!gate |=> (base_req == `EIRQ_RESET_BYTE &&
		ext1_req == `EIRQ_RESET_BYTE && ext2_req == `EIRQ_RESET_BYTE))
		else $error("request passed with global gate clear");
	req_enable_a: assert property (
		base_req[`EIRQ_SRC_REQ2] |-> $past(en2 && pend2))
		else $error("request 2 forwarded while disabled");
	req3_enable_a: assert property (
		base_req[`EIRQ_SRC_REQ3] |-> $past(en3 && pend3))
		else $error("request 3 forwarded while disabled");
	ext2_gate_a: assert property (
		(ext2_req & ~$past(st_r.ext_en_two)) == `EIRQ_RESET_BYTE)
		else $error("extended two request while disabled");
	keypad_gate_a: assert property (
		ext1_req[`EIRQ_BIT_KEYPAD] |->
		$past(st_r.ext_en_one[`EIRQ_BIT_KEYPAD] &&
		src.ext1_raw[`EIRQ_BIT_KEYPAD]))
		else $error("keypad request while disabled");
	conv_gate_a: assert property (
		ext1_req[`EIRQ_BIT_CONV] |->
		$past(st_r.ext_en_one[`EIRQ_BIT_CONV] &&
		src.ext1_raw[`EIRQ_BIT_CONV]))
		else $error("conversion request while disabled");
	spi_gate_a: assert property (
		ext1_req[`EIRQ_BIT_SPI] |->
		$past(st_r.ext_en_one[`EIRQ_BIT_SPI] &&
		src.ext1_raw[`EIRQ_BIT_SPI]))
		else $error("transfer request while disabled");
	sys_group_a: assert property (
		ext1_req[`EIRQ_BIT_SYSFLAG] |->
		$past(st_r.ext_en_one[`EIRQ_BIT_SYSFLAG] && sys_any))
		else $error("system flag request without enables");
	// Wake-up from idle or power-down
	wake_sleep_a: assert property (
		wake_up |-> $past(idle_state || power_down_state))
		else $error("wake outside sleep");
	wake_enabled_a: assert property (
		((idle_state || power_down_state) && en3 && pend3 && !bus.wr &&
		!service_req3 && (st_r.xreq_ctrl[`EIRQ_BIT_EDGE3] || lvl3))
		|=> wake_up)
		else $error("enabled pending request did not wake");
	wake_disabled_a: assert property (
		(!en2 && !en3) ##1 (!en2 && !en3) |-> !wake_up)
		else $error("wake from disabled request");
	// Pending flag set, clear and tracking
	pend_edge_a: assert property (
		(edge2 && st_r.xreq_ctrl[`EIRQ_BIT_EDGE2]) |=> pend2)
		else $error("edge did not set pending");
	pend_service_a: assert property (
		(service_req3 && st_r.xreq_ctrl[`EIRQ_BIT_EDGE3] && !edge3 &&
		!bus.wr) |=> !pend3)
		else $error("service did not clear pending");
	pend_level_a: assert property (
		(!st_r.xreq_ctrl[`EIRQ_BIT_EDGE2] && !bus.wr) |=>
		pend2 == $past(lvl2))
		else $error("level pending does not track pin");
	// Reserved bit, write hold-off and priority pairs
	reserved_zero_a: assert property (
		!st_r.ext_en_two[`EIRQ_BIT_RSVD5])
		else $error("reserved enable bit set");
	write_block_a: assert property (
		reg_wr |=> vector_block [*2])
		else $error("vectoring not blocked after write");
	level_pair_a: assert property (
		(st_r.base_pri_high[`EIRQ_SRC_REQ3] &&
		st_r.base_pri_low[`EIRQ_SRC_REQ3])
		|=> base_level[2 * `EIRQ_SRC_REQ3 +: 2] == EIRQ_LVL1)
		else $error("priority pair wrong");
	// Main scenarios
	wake_seen_c: cover property (
		(idle_state || power_down_state) ##1 wake_up);
	edge_pend_c: cover property (
		edge3 ##2 base_req[`EIRQ_SRC_REQ3]);
	block_seen_c: cover property (
		reg_wr ##1 vector_block ##[1:8] !vector_block);
	level_track_c: cover property (
		!st_r.xreq_ctrl[`EIRQ_BIT_EDGE2] && lvl2 ##1 pend2);
endmodule

// *** eirq_far_model.sv ***
// Peripheral flags and external pins seen by the interrupt block
`timescale 1ns/1ps
module eirq_far_model
	import eirq_pkg::*;
(
	// Clock
	input wire logic clock,
	// Commanded levels
	input wire eirq_src_s src_cmd,
	input wire logic pin2_cmd,
	input wire logic pin3_cmd,
	// Lines into the block
	output eirq_src_s src,
	output logic external_request_2_pin,
	output logic external_request_3_pin
);
	// Flags and pins move only off the sampling edge
	always @(negedge clock) begin
		src <= src_cmd;
		external_request_2_pin <= pin2_cmd;
		external_request_3_pin <= pin3_cmd;
	end
endmodule

// *** testbench.sv ***
// Register and request tests of the interrupt control block
`timescale 1ns/1ps
module testbench
	import eirq_pkg::*;
;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	eirq_bus_s bus = '0;
	logic idle_state = 1'b0;
	logic power_down_state = 1'b0;
	logic instr_end = 1'b0;
	logic service_req2 = 1'b0;
	logic service_req3 = 1'b0;
	eirq_src_s src_cmd = '0;
	logic pin2_cmd = 1'b1;
	logic pin3_cmd = 1'b1;
	eirq_src_s src;
	logic pin2, pin3, vector_block, wake_up;
	logic [7:0] rdata, base_req, ext1_req, ext2_req;
	logic [15:0] base_level, ext1_level;
	logic [7:0] regs [7] = '{8'hA5, 8'hAD, 8'hAE, 8'hAF, 8'hB6, 8'hB7, 8'hC0};
	int miscompares = 0;
	int comparisons = 0;

	// Clock at 8 ns
	always #4 clock = ~clock;

	eirq_far_model far (.clock(clock), .src_cmd(src_cmd),
		.pin2_cmd(pin2_cmd), .pin3_cmd(pin3_cmd), .src(src),
		.external_request_2_pin(pin2), .external_request_3_pin(pin3));

	eirq_ctrl dut (.clock(clock), .rst_n(rst_n), .bus(bus), .rdata(rdata),
		.idle_state(idle_state), .power_down_state(power_down_state),
		.instr_end(instr_end), .service_req2(service_req2),
		.service_req3(service_req3), .src(src),
		.external_request_2_pin(pin2), .external_request_3_pin(pin3),
		.base_req(base_req), .ext1_req(ext1_req), .ext2_req(ext2_req),
		.base_level(base_level), .ext1_level(ext1_level),
		.vector_block(vector_block), .wake_up(wake_up));

	task automatic tick(input int n);
		repeat (n) @(negedge clock);
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		bus.wr = 1'b1;
		bus.addr = a;
		bus.wdata = d;
		tick(1);
		bus.wr = 1'b0;
		tick(1);
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		bus.rd = 1'b1;
		bus.addr = a;
		tick(1);
		bus.rd = 1'b0;
		d = rdata;
		tick(1);
	endtask

	task automatic stop_test;
		$display("Counts: %0d mismatches, %0d comparisons", miscompares,
			comparisons);
		if (miscompares == 0 && comparisons > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic chk_out(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_reg(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] got;
		rd(a, got);
		comparisons++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR at %0t: reg %h read %h, expected %h", $time, a,
				got, exp);
		end
	endtask

	task automatic pulse_end;
		instr_end = 1'b1;
		tick(1);
		instr_end = 1'b0;
		tick(1);
	endtask

	// Expected level pairs, high bit above low bit
	function automatic logic [15:0] pair(input logic [7:0] h,
		input logic [7:0] l);
		for (int i = 0; i < 8; i++) begin
			pair[2 * i +: 2] = {h[i], l[i]};
		end
	endfunction

	// Watchdog on a hung run
	initial begin
		#200000;
		miscompares++;
		stop_test();
	end

	initial begin
		tick(6);
		rst_n = 1'b1;
		tick(1);
		// Reset values and read-back
		for (int i = 0; i < 7; i++) begin
			chk_reg(regs[i], 8'h00);
		end
		chk_out({ext1_req, ext2_req}, 16'h0000);
		for (int i = 0; i < 6; i++) begin
			wr(regs[i], (i == 0) ? 8'h1C : 8'h3C);
			chk_reg(regs[i], (i == 0) ? 8'h1C : 8'h3C);
		end
		wr(8'h10, 8'hFF);
		chk_reg(8'h10, 8'h00);
		src_cmd.ext1_raw = 8'hFF;
		src_cmd.ext2_raw = 7'h7F;
		src_cmd.base_raw = 8'hFF;
		wr(8'hAD, 8'hFF);
		wr(8'hA5, 8'hDF);
		wr(8'hC8, 8'h00);
		tick(3);
		chk_out({ext1_req, ext2_req}, 16'h0000);
		chk_out({8'h00, base_req}, 16'h0000);
		wr(8'hC8, 8'h01);
		tick(3);
		chk_out({ext1_req, ext2_req}, 16'hF7DF);
		chk_out({8'h00, base_req}, 16'h003F);
		for (int i = 0; i < 8; i++) begin
			wr(8'hAD, 8'h01 << i);
			wr(8'hA5, (8'h01 << i) & 8'hDF);
			tick(3);
			chk_out({ext1_req, ext2_req}, {(8'h01 << i) & 8'hF7,
				(8'h01 << i) & 8'hDF});
		end
		wr(8'hAD, 8'hDC);
		tick(3);
		chk_out({8'h00, ext1_req}, 16'h00D4);
		wr(8'hAD, 8'hFF);
		src_cmd.ext1_raw = 8'h00;
		tick(3);
		chk_out({8'h00, ext1_req}, 16'h0000);
		src_cmd.sys_flags = 10'h3FF;
		wr(8'hC9, 8'h00);
		tick(3);
		chk_out({8'h00, ext1_req}, 16'h0000);
		wr(8'hC9, 8'hFF);
		wr(8'hC8, 8'h03);
		tick(3);
		chk_out({8'h00, ext1_req}, 16'h0008);
		wr(8'hAD, 8'hF7);
		tick(3);
		chk_out({8'h00, ext1_req}, 16'h0000);
		wr(8'hB7, 8'hCC);
		wr(8'hB6, 8'hAA);
		wr(8'hAF, 8'hF0);
		wr(8'hAE, 8'h3C);
		tick(3);
		chk_out(base_level, pair(8'hCC, 8'hAA));
		chk_out(ext1_level, pair(8'hF0, 8'h3C));
		pulse_end();
		pulse_end();
		chk_out({15'h0000, vector_block}, 16'h0000);
		wr(8'hC8, 8'h01);
		chk_out({15'h0000, vector_block}, 16'h0001);
		pulse_end();
		chk_out({15'h0000, vector_block}, 16'h0001);
		pulse_end();
		tick(1);
		chk_out({15'h0000, vector_block}, 16'h0000);
		wr(8'hC0, 8'h05);
		pin2_cmd = 1'b0;
		tick(6);
		chk_out({14'h0000, base_req[7:6]}, 16'h0001);
		chk_reg(8'hC0, 8'h07);
		service_req2 = 1'b1;
		tick(1);
		service_req2 = 1'b0;
		tick(3);
		chk_reg(8'hC0, 8'h05);
		wr(8'hC0, 8'h0D);
		pin2_cmd = 1'b1;
		tick(6);
		chk_reg(8'hC0, 8'h0F);
		wr(8'hC0, 8'h0B);
		tick(3);
		chk_out({14'h0000, base_req[7:6]}, 16'h0000);
		wr(8'hC0, 8'h04);
		tick(3);
		chk_out({14'h0000, base_req[7:6]}, 16'h0000);
		pin2_cmd = 1'b0;
		tick(6);
		chk_out({14'h0000, base_req[7:6]}, 16'h0001);
		pin2_cmd = 1'b1;
		tick(6);
		chk_out({14'h0000, base_req[7:6]}, 16'h0000);
		idle_state = 1'b1;
		wr(8'hC0, 8'h50);
		pin3_cmd = 1'b0;
		tick(6);
		chk_out({15'h0000, wake_up}, 16'h0001);
		chk_reg(8'hC0, 8'h70);
		idle_state = 1'b0;
		power_down_state = 1'b1;
		wr(8'hC0, 8'h10);
		pin3_cmd = 1'b1;
		tick(2);
		pin3_cmd = 1'b0;
		tick(6);
		chk_reg(8'hC0, 8'h30);
		chk_out({15'h0000, wake_up}, 16'h0000);
		stop_test();
	end
endmodule
